// *** inc/param_bank_pkg.sv ***
// Shared constants for the parameter write-protect bank
package param_bank_pkg;
	// Bus and word geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam int IDX_W = 5;
	localparam int GRP_W = 2;
	localparam int GROUPS = 4;
	localparam int DEPTH = 32;
	localparam int CTL_BIT = 7;
	localparam int GRP_LSB = 5;
	localparam int SYNC_STAGES = 3;

	// Parameter groups, taken from address bits above the index
	localparam logic [1:0] GRP_BASIC = 2'h0;
	localparam logic [1:0] GRP_GAIN = 2'h1;
	localparam logic [1:0] GRP_EXT = 2'h2;
	localparam logic [1:0] GRP_IO = 2'h3;

	// Write-lock levels
	localparam logic [15:0] LOCK_BASIC = 16'h0000;
	localparam logic [15:0] LOCK_STD = 16'h000B;
	localparam logic [15:0] LOCK_ALL = 16'h000C;
	localparam logic [15:0] LOCK_RO_BASIC = 16'h100B;
	localparam logic [15:0] LOCK_RO_ALL = 16'h100C;

	// Word index of each named parameter inside the basic group
	localparam logic [4:0] IDX_BRAKE = 5'h02;
	localparam logic [4:0] IDX_MTURN = 5'h03;
	localparam logic [4:0] IDX_FSEL = 5'h04;
	localparam logic [4:0] IDX_TUNE = 5'h08;
	localparam logic [4:0] IDX_RESP = 5'h09;
	localparam logic [4:0] IDX_SETTLE = 5'h0A;
	localparam logic [4:0] IDX_ROT = 5'h0E;
	localparam logic [4:0] IDX_ENC = 5'h0F;
	localparam logic [4:0] IDX_LOCK = 5'h13;

	// Reset values of the named parameters
	localparam logic [15:0] RST_ZERO = 16'h0000;
	localparam logic [15:0] RST_TUNE = 16'h0001;
	localparam logic [15:0] RST_RESP = 16'h000C;
	localparam logic [15:0] RST_SETTLE = 16'h0064;
	localparam logic [15:0] RST_ENC = 16'h0FA0;
	localparam logic [15:0] RST_LOCK = 16'h000B;

	// Control space addresses (address bit 7 set)
	localparam logic [7:0] CTL_STATUS = 8'h80;
	localparam logic [7:0] CTL_MASK = 8'h81;
	localparam logic [7:0] CTL_LOCK_ACT = 8'h82;
	localparam logic [7:0] CTL_ALARM = 8'h83;

	// Sticky status bits
	localparam int ST_W = 3;
	localparam int ST_PARAM_ERR = 0;
	localparam int ST_WR_REJ = 1;
	localparam int ST_RD_REJ = 2;

	// Alarm code 37 decimal
	localparam logic [7:0] ALARM_PARAM = 8'h25;
	localparam logic [7:0] ALARM_NONE = 8'h00;

	// Forced-stop selection digit of function select A-1
	localparam int FSEL_HALT_LSB = 8;
	localparam logic [3:0] FSEL_HALT_OFF = 4'h1;

	// Braking-resistor selection codes (low byte)
	localparam logic [7:0] BRAKE_NONE = 8'h00;
	localparam logic [7:0] BRAKE_EXT_LO = 8'h01;
	localparam logic [7:0] BRAKE_EXT_HI = 8'h09;
	localparam logic [7:0] BRAKE_GAP = 8'h07;
	localparam logic [7:0] BRAKE_HV_LO = 8'h80;
	localparam logic [7:0] BRAKE_HV_HI = 8'h85;
	localparam logic [7:0] BRAKE_FAN = 8'hFA;
endpackage : param_bank_pkg

// *** src/pin_sync.sv ***
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module pin_sync #(
	parameter int STAGES = param_bank_pkg::SYNC_STAGES
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic pin_in,
	output logic level_out
);
	// Shift chain; stage 0 is read only by stage 1
	logic [STAGES-1:0] chain;

	// Chain shifts every edge
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			chain <= '0;
		end else begin
			chain <= {chain[STAGES-2:0], pin_in};
		end
	end

	// Accept a change only once the last two stages agree
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			level_out <= 1'b0;
		end else if (chain[STAGES-1] == chain[STAGES-2]) begin
			level_out <= chain[STAGES-1];
		end
	end
endmodule : pin_sync

// *** src/param_bank.sv ***
// Parameter bank with write-lock gating, deferred apply and alarms
//
// Function
// - Lock 0000h/000Bh/000Ch open one, three, four groups
// - 100Bh/100Ch read-only; only lock word writable
// - Lock level resets to 000Bh
// - Starred parameters apply at power-up or controller reset
// - Braking selection applies at power-up only
// - Unsupported braking code raises alarm 37
// - Decode braking code: none, external, fan-cooled
// - Multi-turn keep used only in position mode
// - Forced-stop digit 1 holds halt released
// - Four groups: basic, gain, extension, I/O
//
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
module param_bank (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [param_bank_pkg::ADDR_W-1:0] addr_in,
	input wire logic [param_bank_pkg::DATA_W-1:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [param_bank_pkg::DATA_W-1:0] rdata_out,
	input wire logic ctrl_reset_in,
	input wire logic position_mode_in,
	input wire logic emergency_halt_in,
	output logic halt_active_out,
	output logic param_error_out,
	output logic [7:0] alarm_code_out,
	output logic irq_out,
	output logic [7:0] brake_code_out,
	output logic brake_ext_out,
	output logic brake_fan_out,
	output logic [param_bank_pkg::DATA_W-1:0] multi_turn_keep_out,
	output logic [param_bank_pkg::DATA_W-1:0] rotation_sense_out,
	output logic [param_bank_pkg::DATA_W-1:0] encoder_pulse_count_out,
	output logic [param_bank_pkg::DATA_W-1:0] gain_tuning_mode_out,
	output logic [param_bank_pkg::DATA_W-1:0] tuning_responsiveness_out,
	output logic [param_bank_pkg::DATA_W-1:0] settle_window_out
);
	localparam int DW = param_bank_pkg::DATA_W;
	localparam int IW = param_bank_pkg::IDX_W;

	// Reset value of one stored word
	function automatic logic [15:0] reset_word(input int grp, input int idx);
		logic [15:0] val;
		val = param_bank_pkg::RST_ZERO;
		if (grp == 0) begin
			case (idx)
				param_bank_pkg::IDX_TUNE: val = param_bank_pkg::RST_TUNE;
				param_bank_pkg::IDX_RESP: val = param_bank_pkg::RST_RESP;
				param_bank_pkg::IDX_SETTLE: val = param_bank_pkg::RST_SETTLE;
				param_bank_pkg::IDX_ENC: val = param_bank_pkg::RST_ENC;
				param_bank_pkg::IDX_LOCK: val = param_bank_pkg::RST_LOCK;
				default: val = param_bank_pkg::RST_ZERO;
			endcase
		end
		return val;
	endfunction : reset_word

	// Groups visible for reading at a lock level
	function automatic logic read_ok(input logic [15:0] lvl, input logic [1:0] grp);
		logic ok;
		ok = (grp == param_bank_pkg::GRP_BASIC);
		case (lvl)
			param_bank_pkg::LOCK_STD: ok = (grp != param_bank_pkg::GRP_IO);
			param_bank_pkg::LOCK_ALL: ok = 1'b1;
			param_bank_pkg::LOCK_RO_ALL: ok = 1'b1;
			default: ok = (grp == param_bank_pkg::GRP_BASIC);
		endcase
		return ok;
	endfunction : read_ok

	// Groups open for writing at a lock level; unknown levels lock everything
	function automatic logic write_ok(input logic [15:0] lvl, input logic [1:0] grp);
		logic ok;
		ok = 1'b0;
		case (lvl)
			param_bank_pkg::LOCK_BASIC: ok = (grp == param_bank_pkg::GRP_BASIC);
			param_bank_pkg::LOCK_STD: ok = (grp != param_bank_pkg::GRP_IO);
			param_bank_pkg::LOCK_ALL: ok = 1'b1;
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction : write_ok

	// Braking codes this drive supports; 07 is a hole in the list
	function automatic logic brake_supported(input logic [7:0] code);
		return (code == param_bank_pkg::BRAKE_NONE) ||
			((code >= param_bank_pkg::BRAKE_EXT_LO) &&
			(code <= param_bank_pkg::BRAKE_EXT_HI) &&
			(code != param_bank_pkg::BRAKE_GAP)) ||
			((code >= param_bank_pkg::BRAKE_HV_LO) &&
			(code <= param_bank_pkg::BRAKE_HV_HI)) ||
			(code == param_bank_pkg::BRAKE_FAN);
	endfunction : brake_supported

	// Stored parameter words, one array per group
	logic [DW-1:0] mem [0:param_bank_pkg::GROUPS-1][0:param_bank_pkg::DEPTH-1];
	// Values in effect; only loaded at power-up or controller reset
	logic [DW-1:0] act_brake;
	logic [DW-1:0] act_mturn;
	logic [DW-1:0] act_fsel;
	logic [DW-1:0] act_rot;
	logic [DW-1:0] act_enc;
	logic [DW-1:0] act_lock;
	// Low for the first cycle after reset release
	logic boot_done;
	// Interrupt state
	logic [param_bank_pkg::ST_W-1:0] status;
	logic [param_bank_pkg::ST_W-1:0] mask;
	logic [param_bank_pkg::ST_W-1:0] next_status;
	// Filtered external halt request
	logic halt_req;

	// Address decode
	wire ctl_space = addr_in[param_bank_pkg::CTL_BIT];
	wire [1:0] grp_sel = addr_in[param_bank_pkg::GRP_LSB +: param_bank_pkg::GRP_W];
	wire [IW-1:0] idx_sel = addr_in[IW-1:0];
	wire is_lock_word = (grp_sel == param_bank_pkg::GRP_BASIC) &&
		(idx_sel == param_bank_pkg::IDX_LOCK);
	// Lock word itself is always writable so software can unlock
	wire wr_allowed = is_lock_word || write_ok(act_lock, grp_sel);
	wire wr_param = wr_in && !ctl_space;
	wire wr_commit = wr_param && wr_allowed;
	wire wr_reject = wr_param && !wr_allowed;
	wire rd_allowed = read_ok(act_lock, grp_sel);
	wire rd_reject = rd_in && !ctl_space && !rd_allowed;
	wire wr_ctl_status = wr_in && (addr_in == param_bank_pkg::CTL_STATUS);
	wire wr_ctl_mask = wr_in && (addr_in == param_bank_pkg::CTL_MASK);
	// Load strobes for the values in effect
	wire power_load = !boot_done;
	wire ctrl_load = ctrl_reset_in && boot_done;
	wire star_load = power_load || ctrl_load;
	// Derived conditions
	wire brake_bad = !brake_supported(act_brake[7:0]);
	wire halt_off = act_fsel[param_bank_pkg::FSEL_HALT_LSB +: 4] ==
		param_bank_pkg::FSEL_HALT_OFF;
	wire [param_bank_pkg::ST_W-1:0] st_set = {rd_reject, wr_reject, brake_bad && boot_done};
	wire [param_bank_pkg::ST_W-1:0] st_clr = wr_ctl_status ? wdata_in[param_bank_pkg::ST_W-1:0] : '0;

	// Read mux for the bus
	logic [DW-1:0] rd_value;
	always_comb begin
		rd_value = '0;
		if (!ctl_space) begin
			rd_value = rd_allowed ? mem[grp_sel][idx_sel] : '0;
		end else begin
			case (addr_in)
				param_bank_pkg::CTL_STATUS: rd_value = DW'(status);
				param_bank_pkg::CTL_MASK: rd_value = DW'(mask);
				param_bank_pkg::CTL_LOCK_ACT: rd_value = act_lock;
				param_bank_pkg::CTL_ALARM: rd_value = DW'(alarm_code_out);
				default: rd_value = '0;
			endcase
		end
	end

	// Sticky bits: a set in the clearing cycle survives
	assign next_status = (status & ~st_clr) | st_set;

	// Storage words; each word has its own enable and reset value
	for (genvar g = 0; g < param_bank_pkg::GROUPS; g++) begin : g_grp
		for (genvar i = 0; i < param_bank_pkg::DEPTH; i++) begin : g_word
			wire hit = wr_commit && (grp_sel == g) && (idx_sel == i);
			always_ff @(posedge clk_in or posedge rst_in) begin
				if (rst_in) begin
					mem[g][i] <= reset_word(g, i);
				end else if (hit) begin
					mem[g][i] <= wdata_in;
				end
			end
		end
	end

	// Boot flag marks the power-up load cycle
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			boot_done <= 1'b0;
		end else begin
			boot_done <= 1'b1;
		end
	end

	// Braking selection: power-up only, a controller reset does not apply it
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			act_brake <= param_bank_pkg::RST_ZERO;
		end else if (power_load) begin
			act_brake <= mem[param_bank_pkg::GRP_BASIC][param_bank_pkg::IDX_BRAKE];
		end
	end

	// Starred parameters: power-up or controller reset
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			act_mturn <= param_bank_pkg::RST_ZERO;
			act_fsel <= param_bank_pkg::RST_ZERO;
			act_rot <= param_bank_pkg::RST_ZERO;
			act_enc <= param_bank_pkg::RST_ENC;
			act_lock <= param_bank_pkg::RST_LOCK;
		end else if (star_load) begin
			act_mturn <= mem[param_bank_pkg::GRP_BASIC][param_bank_pkg::IDX_MTURN];
			act_fsel <= mem[param_bank_pkg::GRP_BASIC][param_bank_pkg::IDX_FSEL];
			act_rot <= mem[param_bank_pkg::GRP_BASIC][param_bank_pkg::IDX_ROT];
			act_enc <= mem[param_bank_pkg::GRP_BASIC][param_bank_pkg::IDX_ENC];
			act_lock <= mem[param_bank_pkg::GRP_BASIC][param_bank_pkg::IDX_LOCK];
		end
	end

	// Interrupt status and mask
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			status <= '0;
			mask <= '0;
		end else begin
			status <= next_status;
			if (wr_ctl_mask) begin
				mask <= wdata_in[param_bank_pkg::ST_W-1:0];
			end
		end
	end

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			rdata_out <= '0;
		end else begin
			rdata_out <= rd_in ? rd_value : '0;
		end
	end

	// External halt passes the pin filter
	pin_sync #(
		.STAGES(param_bank_pkg::SYNC_STAGES)
	) u_halt_sync (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.pin_in(emergency_halt_in),
		.level_out(halt_req)
	);

	// Drive-facing outputs, all registered
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			halt_active_out <= 1'b0;
			param_error_out <= 1'b0;
			alarm_code_out <= param_bank_pkg::ALARM_NONE;
			brake_code_out <= param_bank_pkg::BRAKE_NONE;
			brake_ext_out <= 1'b0;
			brake_fan_out <= 1'b0;
			multi_turn_keep_out <= '0;
		end else begin
			// Deselected input reads as permanently released
			halt_active_out <= halt_off ? 1'b0 : halt_req;
			param_error_out <= brake_bad;
			alarm_code_out <= brake_bad ? param_bank_pkg::ALARM_PARAM :
				param_bank_pkg::ALARM_NONE;
			brake_code_out <= act_brake[7:0];
			brake_ext_out <= !brake_bad && (act_brake[7:0] != param_bank_pkg::BRAKE_NONE) &&
				(act_brake[7:0] != param_bank_pkg::BRAKE_FAN);
			brake_fan_out <= act_brake[7:0] == param_bank_pkg::BRAKE_FAN;
			// Speed mode ignores the multi-turn keep selection
			multi_turn_keep_out <= position_mode_in ? act_mturn : '0;
		end
	end

	// Level interrupt from any unmasked sticky bit
	assign irq_out = |(status & mask);
	// Values in effect straight from flops
	assign rotation_sense_out = act_rot;
	assign encoder_pulse_count_out = act_enc;
	// Tuning words act as soon as written
	assign gain_tuning_mode_out = mem[param_bank_pkg::GRP_BASIC][param_bank_pkg::IDX_TUNE];
	assign tuning_responsiveness_out = mem[param_bank_pkg::GRP_BASIC][param_bank_pkg::IDX_RESP];
	assign settle_window_out = mem[param_bank_pkg::GRP_BASIC][param_bank_pkg::IDX_SETTLE];

	// Checks, all on the one clock
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	// Write to a closed group
	sequence s_closed_write;
		wr_in && !ctl_space && (act_lock == param_bank_pkg::LOCK_BASIC) &&
			(grp_sel != param_bank_pkg::GRP_BASIC);
	endsequence
	// Write to any word but the lock word in read-only levels
	sequence s_ro_write;
		wr_in && !ctl_space && !is_lock_word &&
			((act_lock == param_bank_pkg::LOCK_RO_BASIC) ||
			(act_lock == param_bank_pkg::LOCK_RO_ALL));
	endsequence

	closed_group_a: assert property (s_closed_write |=> status[param_bank_pkg::ST_WR_REJ])
		else $error("closed group write not flagged");
	ro_write_a: assert property (s_ro_write |=> status[param_bank_pkg::ST_WR_REJ])
		else $error("read-only level accepted a write");
	ro_read_a: assert property (rd_in && !ctl_space && (grp_sel != param_bank_pkg::GRP_BASIC) &&
			(act_lock == param_bank_pkg::LOCK_RO_BASIC) |=> (rdata_out == '0) &&
			status[param_bank_pkg::ST_RD_REJ])
		else $error("hidden group was readable");
	lock_reset_a: assert property (power_load |->
			mem[param_bank_pkg::GRP_BASIC][param_bank_pkg::IDX_LOCK] == param_bank_pkg::RST_LOCK)
		else $error("lock level not at factory value");
	deferred_apply_a: assert property (boot_done && !ctrl_reset_in |=> $stable(act_rot) &&
			$stable(act_lock) && $stable(act_enc))
		else $error("starred value applied without reset");
	brake_power_a: assert property (boot_done |=> $stable(act_brake))
		else $error("braking selection changed after power-up");
	brake_alarm_a: assert property (boot_done && brake_bad |=> param_error_out ##0
			alarm_code_out == param_bank_pkg::ALARM_PARAM ##1 status[param_bank_pkg::ST_PARAM_ERR])
		else $error("unsupported braking code not alarmed");
	speed_mode_a: assert property (!position_mode_in |=> multi_turn_keep_out == '0)
		else $error("multi-turn keep used outside position mode");
	halt_release_a: assert property (halt_off [*2] |=> !halt_active_out)
		else $error("forced stop not held released");
	reject_hold_a: assert property (wr_reject && (grp_sel == param_bank_pkg::GRP_GAIN) |=>
			mem[param_bank_pkg::GRP_GAIN][$past(idx_sel)] == $past(mem[param_bank_pkg::GRP_GAIN][idx_sel]))
		else $error("rejected write changed a word");
endmodule : param_bank

// *** dv/bus_host.sv ***
// Register bus master standing in for the motion controller
`timescale 1ns/100ps
module bus_host (
	input wire logic clk_in,
	output logic [7:0] addr_out,
	output logic [15:0] wdata_out,
	output logic wr_out,
	output logic rd_out,
	input wire logic [15:0] rdata_in
);
	// Idle bus from time zero
	initial begin
		addr_out = 8'h00;
		wdata_out = 16'h0000;
		wr_out = 1'b0;
		rd_out = 1'b0;
	end

	// One-cycle write; words go straight in, lock level left alone
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_in);
		addr_out <= a;
		wdata_out <= d;
		wr_out <= 1'b1;
		@(posedge clk_in);
		wr_out <= 1'b0;
		// Stale data not left standing on the bus
		wdata_out <= ~d;
	endtask : wr

	// One-cycle read; data taken in the cycle after the strobe only
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk_in);
		addr_out <= a;
		rd_out <= 1'b1;
		@(posedge clk_in);
		rd_out <= 1'b0;
		#1;
		d = rdata_in;
	endtask : rd
endmodule : bus_host

// *** dv/testbench.sv ***
// Self-checking bench for the parameter bank against a behavioural model
`timescale 1ns/100ps
module testbench;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic ctrl_reset_in = 1'b0;
	logic position_mode_in = 1'b0;
	logic emergency_halt_in = 1'b0;
	logic [7:0] addr, alarm, brake_code;
	logic [15:0] wdata, rdata, mturn, rot, enc, tune, resp, settle;
	logic wr, rd, halt, perr, irq, b_ext, b_fan;
	int n_mismatch = 0;
	int checks = 0;
	int seed = 46929;
	// Model state: stored words, values in effect, status and mask
	int mem[128];
	int elock, erot, eenc, efsel, emt, st, msk;
	int idx_list[9] = '{'h02, 'h03, 'h04, 'h08, 'h09, 'h0A, 'h0E, 'h0F, 'h13};
	int levels[6] = '{'h0000, 'h100B, 'h100C, 'h0005, 'h000B, 'h000C};
	logic [15:0] v;

	// 250 MHz clock
	always #2 clk_in = ~clk_in;

	bus_host host (.clk_in(clk_in), .addr_out(addr), .wdata_out(wdata), .wr_out(wr),
		.rd_out(rd), .rdata_in(rdata));

	param_bank dut (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr), .wdata_in(wdata),
		.wr_in(wr), .rd_in(rd), .rdata_out(rdata), .ctrl_reset_in(ctrl_reset_in),
		.position_mode_in(position_mode_in), .emergency_halt_in(emergency_halt_in),
		.halt_active_out(halt), .param_error_out(perr), .alarm_code_out(alarm),
		.irq_out(irq), .brake_code_out(brake_code), .brake_ext_out(b_ext),
		.brake_fan_out(b_fan), .multi_turn_keep_out(mturn), .rotation_sense_out(rot),
		.encoder_pulse_count_out(enc), .gain_tuning_mode_out(tune),
		.tuning_responsiveness_out(resp), .settle_window_out(settle));

	// Single comparison point
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %0t %s seen %h exp %h", $time, what, seen, exp);
		end
	endtask : check

	// Verdict and end of run
	task automatic test_done;
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : test_done

	// Group visibility under the lock level in effect
	function automatic bit can_rd(int g);
		if (elock == 'h000C || elock == 'h100C) return 1'b1;
		if (elock == 'h000B) return g != 3;
		return g == 0;
	endfunction : can_rd

	// Writability; read-only and unknown levels leave only the lock word
	function automatic bit can_wr(int g, int i);
		if (elock == 'h000C) return 1'b1;
		if (elock == 'h000B) return g != 3;
		if (elock == 'h0000) return g == 0;
		return g == 0 && i == 'h13;
	endfunction : can_wr

	// Write through the bus and mirror it in the model
	task automatic mwr(input logic [7:0] a, input logic [15:0] d);
		host.wr(a, d);
		if (a == 8'h80) st &= ~int'(d);
		else if (a == 8'h81) msk = d & 7;
		else if (!a[7]) begin
			if (can_wr(a[6:5], a[4:0])) mem[a[6:0]] = d;
			else st |= 2;
		end
	endtask : mwr

	// Read through the bus and compare with the model
	task automatic mrd(input logic [7:0] a);
		int e;
		host.rd(a, v);
		e = 0;
		if (a == 8'h80) e = st;
		else if (a == 8'h81) e = msk;
		else if (a == 8'h82) e = elock;
		else if (!a[7]) begin
			if (can_rd(a[6:5])) e = mem[a[6:0]];
			else st |= 4;
		end
		check(v, 16'(e), "read");
	endtask : mrd

	// Controller reset: starred words go into effect, braking code does not
	task automatic ctrl_rst;
		@(posedge clk_in);
		ctrl_reset_in <= 1'b1;
		@(posedge clk_in);
		ctrl_reset_in <= 1'b0;
		elock = mem['h13];
		emt = mem['h03];
		efsel = mem['h04];
		erot = mem['h0E];
		eenc = mem['h0F];
		repeat (2) @(posedge clk_in);
	endtask : ctrl_rst

	// Compare the status outputs except halt with the model
	task automatic check_outs;
		@(posedge clk_in);
		#1;
		check(rot, 16'(erot), "rotation");
		check(enc, 16'(eenc), "encoder");
		check(mturn, position_mode_in ? 16'(emt) : 16'h0000, "multi turn");
		check(brake_code, 8'h00, "brake code");
		check({b_ext, b_fan, perr}, 3'h0, "brake flags");
		check(alarm, 8'h00, "alarm");
		check(tune, 16'(mem['h08]), "tuning mode");
		check(resp, 16'(mem['h09]), "response");
		check(settle, 16'(mem['h0A]), "settle");
		check(irq, (st & msk) != 0, "irq");
	endtask : check_outs

	// Watchdog, far beyond the expected run of a few hundred cycles
	initial begin
		#200000;
		n_mismatch++;
		test_done();
	end

	// Main sequence
	initial begin
		foreach (mem[i]) mem[i] = 0;
		mem['h08] = 'h0001;
		mem['h09] = 'h000C;
		mem['h0A] = 'h0064;
		mem['h0F] = 'h0FA0;
		mem['h13] = 'h000B;
		elock = 'h000B;
		erot = 0;
		eenc = 'h0FA0;
		efsel = 0;
		emt = 0;
		st = 0;
		msk = 0;
		repeat (16) @(posedge clk_in);
		rst_in <= 1'b0;
		// Boot edge passes before the first request
		repeat (2) @(posedge clk_in);
		check_outs();
		foreach (idx_list[i]) mrd(8'(idx_list[i]));
		mrd(8'h82);
		$display("test reset_values done");
		// Every lock level, applied only by controller reset
		foreach (levels[k]) begin
			mwr(8'h13, 16'(levels[k]));
			mrd(8'h82);
			ctrl_rst();
			mrd(8'h82);
			for (int g = 0; g < 4; g++) begin
				mwr(8'(g * 32 + 5), 16'($random(seed)));
				mrd(8'(g * 32 + 5));
			end
			mrd(8'h80);
			mwr(8'h80, 16'h0007);
		end
		$display("test lock_levels done");
		// Deferred apply of starred words and braking code
		mwr(8'h0E, 16'h0001);
		mwr(8'h0F, 16'($random(seed)));
		mwr(8'h03, 16'($random(seed)));
		mwr(8'h02, 16'h0003);
		mwr(8'h08, 16'($random(seed)));
		check_outs();
		position_mode_in <= 1'b1;
		ctrl_rst();
		check_outs();
		position_mode_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		check_outs();
		mwr(8'h02, 16'h0000);
		$display("test deferred_apply done");
		// Forced-stop input ignored while deselected
		emergency_halt_in <= 1'b1;
		mwr(8'h04, 16'h0100);
		ctrl_rst();
		repeat (8) @(posedge clk_in);
		// Sample off the edge that launches the registered halt output
		#1;
		check(halt, 1'b0, "halt deselected");
		mwr(8'h04, 16'h0000);
		ctrl_rst();
		repeat (8) @(posedge clk_in);
		#1;
		check(halt, 1'b1, "halt asserted");
		emergency_halt_in <= 1'b0;
		repeat (8) @(posedge clk_in);
		#1;
		check(halt, 1'b0, "halt released");
		$display("test forced_stop done");
		// Refusals raise sticky status; mask and clear drive irq
		mwr(8'h13, 16'h0000);
		ctrl_rst();
		mwr(8'h25, 16'($random(seed)));
		mrd(8'h45);
		check_outs();
		mwr(8'h81, 16'h0002);
		check_outs();
		mrd(8'h81);
		mrd(8'h80);
		mwr(8'h80, 16'h0002);
		check_outs();
		mwr(8'h81, 16'h0004);
		check_outs();
		mwr(8'h84, 16'($random(seed)));
		mrd(8'h84);
		// Alarm word: braking code in effect is still the power-up zero
		mrd(8'h83);
		mwr(8'h80, 16'h0007);
		check_outs();
		$display("test status_irq done");
		test_done();
	end
endmodule : testbench
